// *** rtca_core.sv ***
// Purpose: date/month alarm compare and both clock control registers
// Assumes: rst_i is power-on reset, mrst_i a manual reset, both sync
// Notes:   crystal time base is derived in-domain; no crossing needed
`timescale 1ns/1ps
module rtca_core
   import rtca_pkg::*;
#(
   parameter int TICK_DIV = RTCA_TICK_CYCLES
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         mrst_i,
   input  wire rtca_wb_req_s wb_req_i,
   input  wire logic         day_carry_i,
   input  wire logic         other_alarm_match_i,
   output rtca_wb_rsp_s      wb_rsp_o,
   output rtca_irq_s         irq_o,
   output logic              osc_run_o,
   output logic              minute_carry_o
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  date_alarm;
      logic [7:0]  month_alarm;
      logic        carry_flag;
      logic        carry_irq_enable;
      logic        alarm_irq_enable;
      logic        alarm_match_flag;
      logic        periodic_flag;
      logic [2:0]  period_select;
      logic        oscillator_run;
      logic        calendar_start;
      logic [RTCA_SUBSEC_WIDTH-1:0] sub_second_counter;
      logic [8:0]  prescale;
      logic        match_seen;
      logic        ack;
      logic [31:0] rdata;
      rtca_irq_s   irq;
      logic        min_carry;
   } rtca_core_s;
   rtca_core_s st, next_st;

   logic       xtal_tick;
   logic       div_clear;
   logic       sub_wrap;
   logic       sec_inc;
   logic       sec_carry;
   logic       sec_load;
   logic       sec_wr;
   logic [7:0] sec_load_val;
   logic [7:0] seconds_counter;
   logic       date_carry;
   logic [7:0] date_counter;
   logic [7:0] month_counter;
   logic       wr_stb;
   logic       rd_stb;
   logic       period_hit;
   logic       alarm_now;
   logic       counter_read;
   logic [7:0] ctl1_wr;
   logic [7:0] ctl2_wr;
   logic [7:0] wdat;

   // ----------------------------------------------------------------
   // time base
   // ----------------------------------------------------------------
   rtca_tick #(
      .DIV (TICK_DIV)
   ) u_tick (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .run_i  (st.oscillator_run),
      .clr_i  (div_clear),
      .tick_o (xtal_tick)
   );

   // bus decode; every valid access is single-cycle, ack registered
   assign wdat   = wb_req_i.dat[7:0];
   assign wr_stb = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we
                   && wb_req_i.sel[0] && !st.ack;
   assign rd_stb = wb_req_i.cyc && wb_req_i.stb && !wb_req_i.we && !st.ack;
   assign ctl1_wr = (wr_stb && wb_req_i.adr == RTCA_CONTROL_ONE_OFS)
                    ? wdat : 8'h00;
   assign ctl2_wr = (wr_stb && wb_req_i.adr == RTCA_CONTROL_TWO_OFS)
                    ? wdat : 8'h00;

   // divider clear from round or divider reset writes
   assign div_clear = ctl2_wr[RTCA_ROUND_BIT]
                      || ctl2_wr[RTCA_DIV_RESET_BIT];

   // 64 Hz tap: the prescaler wraps every 512 crystal ticks
   // one second is 64 sub-second steps; bit 6 toggles each second
   assign sub_wrap = xtal_tick && (st.prescale == 9'h1FF)
                     && (&st.sub_second_counter[5:0]);
   assign sec_inc  = sub_wrap && st.calendar_start;

   // round: 00..29 -> 00, 30..59 -> 00 plus a minute carry
   // software loads seconds only while the calendar is stopped
   assign sec_wr       = wr_stb && !st.calendar_start
                         && wb_req_i.adr == RTCA_SECONDS_OFS;
   assign sec_load     = ctl2_wr[RTCA_ROUND_BIT] || sec_wr;
   assign sec_load_val = ctl2_wr[RTCA_ROUND_BIT] ? 8'h00
                                                 : (wdat & 8'h7F);
   assign minute_carry_o = st.min_carry;

   rtca_bcd #(
      .FIRST (8'h00),
      .LAST  (8'h59)
   ) u_seconds (
      .clk_i      (clk_i),
      .inc_i      (sec_inc),
      .load_i     (sec_load),
      .load_val_i (sec_load_val),
      .val_o      (seconds_counter),
      .carry_o    (sec_carry)
   );

   // date advances on external hour-counter day carry
   rtca_bcd #(
      .FIRST (RTCA_DATE_FIRST),
      .LAST  (8'h31)
   ) u_date (
      .clk_i      (clk_i),
      .inc_i      (day_carry_i && st.calendar_start),
      .load_i     (wr_stb && !st.calendar_start
                   && wb_req_i.adr == RTCA_DATE_OFS),
      .load_val_i (wdat & 8'h3F),
      .val_o      (date_counter),
      .carry_o    (date_carry)
   );

   rtca_bcd #(
      .FIRST (8'h01),
      .LAST  (8'h12)
   ) u_month (
      .clk_i      (clk_i),
      .inc_i      (date_carry),
      .load_i     (wr_stb && !st.calendar_start
                   && wb_req_i.adr == RTCA_MONTH_OFS),
      .load_val_i (wdat & 8'h1F),
      .val_o      (month_counter),
      .carry_o    ()
   );

   // alarm compare over enabled fields only
   always_comb begin
      alarm_now = other_alarm_match_i;
      if (st.date_alarm[RTCA_ENABLE_BIT]
          && st.date_alarm[5:0] != date_counter[5:0]) begin
         alarm_now = 1'b0;
      end
      if (st.month_alarm[RTCA_ENABLE_BIT]
          && st.month_alarm[4:0] != month_counter[4:0]) begin
         alarm_now = 1'b0;
      end
   end

   // periodic select against the prescaler and sub-second counter
   // the seven-bit sub-second counter wraps every two seconds
   always_comb begin
      period_hit = 1'b0;
      unique case (st.period_select)
         3'd0: period_hit = 1'b0;
         3'd1: period_hit = xtal_tick && (st.prescale[6:0] == 7'h7F);
         3'd2: period_hit = xtal_tick && (&st.prescale);
         3'd3: period_hit = xtal_tick && (&st.prescale)
                            && (&st.sub_second_counter[1:0]);
         3'd4: period_hit = xtal_tick && (&st.prescale)
                            && (&st.sub_second_counter[3:0]);
         3'd5: period_hit = xtal_tick && (&st.prescale)
                            && (&st.sub_second_counter[4:0]);
         3'd6: period_hit = sub_wrap;
         3'd7: period_hit = sub_wrap && st.sub_second_counter[6];
      endcase
   end

   // a counter read near a carry is flagged
   assign counter_read = rd_stb && (wb_req_i.adr == RTCA_SECONDS_OFS
                         || wb_req_i.adr == RTCA_SUBSEC_OFS
                         || wb_req_i.adr == RTCA_DATE_OFS
                         || wb_req_i.adr == RTCA_MONTH_OFS);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.ack = 1'b0;
      next_st.rdata = 32'h0000_0000;
      // sub-second chain free-runs, only the oscillator halts it
      if (div_clear) begin
         next_st.prescale = '0;
         next_st.sub_second_counter = '0;
      end else if (xtal_tick) begin
         next_st.prescale = st.prescale + 9'h001;
         if (&st.prescale) begin
            next_st.sub_second_counter = st.sub_second_counter
                                         + 1'b1;
         end
      end
      // direct writes of seconds never carry; a round from 30 or more carries into the minute
      next_st.min_carry = sec_carry
                          || (ctl2_wr[RTCA_ROUND_BIT]
                              && seconds_counter
                              >= RTCA_SECOND_RND);
      // register writes; a write of zero clears a flag
      if (wr_stb) begin
         unique case (wb_req_i.adr)
            RTCA_DATE_ALARM_OFS:  next_st.date_alarm  = wdat
                                                        & RTCA_DATE_MASK;
            RTCA_MONTH_ALARM_OFS: next_st.month_alarm = wdat
                                                        & RTCA_MONTH_MASK;
            RTCA_CONTROL_ONE_OFS: begin
               if (!wdat[RTCA_CARRY_BIT]) next_st.carry_flag = 1'b0;
               if (!wdat[RTCA_ALARM_BIT])
                  next_st.alarm_match_flag = 1'b0;
               next_st.carry_irq_enable = wdat[RTCA_CARRY_IE_BIT];
               next_st.alarm_irq_enable = wdat[RTCA_ALARM_IE_BIT];
            end
            RTCA_CONTROL_TWO_OFS: begin
               if (!wdat[RTCA_PERIODIC_BIT])
                  next_st.periodic_flag = 1'b0;
               next_st.period_select =
                  wdat[RTCA_PSEL_LSB +: 3];
               next_st.oscillator_run = wdat[RTCA_OSC_RUN_BIT];
               next_st.calendar_start = wdat[RTCA_START_BIT];
            end
            default: ;
         endcase
      end
      // hardware sets win over software clears, atomic per edge
      if (counter_read && (sec_inc || sub_wrap || xtal_tick
                           && (&st.prescale)))
         next_st.carry_flag = 1'b1;
      next_st.match_seen = alarm_now;
      if (alarm_now && !st.match_seen
          && (st.date_alarm[RTCA_ENABLE_BIT]
              || st.month_alarm[RTCA_ENABLE_BIT]
              || other_alarm_match_i))
         next_st.alarm_match_flag = 1'b1;
      if (period_hit)
         next_st.periodic_flag = 1'b1;
      // read mux; reserved bits and unmapped addresses read zero
      // every request is answered, a write without the low lane too
      if (wb_req_i.cyc && wb_req_i.stb && !st.ack) begin
         next_st.ack = 1'b1;
      end
      if (rd_stb) begin
         unique case (wb_req_i.adr)
            RTCA_DATE_ALARM_OFS:  next_st.rdata[7:0] = st.date_alarm;
            RTCA_MONTH_ALARM_OFS: next_st.rdata[7:0] = st.month_alarm;
            RTCA_CONTROL_ONE_OFS: next_st.rdata[7:0] =
               {st.carry_flag, 2'b00, st.carry_irq_enable,
                st.alarm_irq_enable, 2'b00, st.alarm_match_flag};
            RTCA_CONTROL_TWO_OFS: next_st.rdata[7:0] =
               {st.periodic_flag, st.period_select, st.oscillator_run,
                2'b00, st.calendar_start};
            RTCA_SECONDS_OFS: next_st.rdata[7:0] = seconds_counter;
            RTCA_DATE_OFS:    next_st.rdata[7:0] = date_counter;
            RTCA_MONTH_OFS:   next_st.rdata[7:0] = month_counter;
            RTCA_SUBSEC_OFS:  next_st.rdata[7:0] =
               {1'b0, st.sub_second_counter};
            default: next_st.rdata = 32'h0000_0000;
         endcase
      end
      // level interrupt requests
      next_st.irq.carry    = next_st.carry_flag
                             && next_st.carry_irq_enable;
      next_st.irq.alarm    = next_st.alarm_match_flag
                             && next_st.alarm_irq_enable;
      next_st.irq.periodic = next_st.periodic_flag
                             && (next_st.period_select != 3'd0);
   end

   // ----------------------------------------------------------------
   // registers: power-on and manual reset
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= next_st;
         st.date_alarm[RTCA_ENABLE_BIT]  <= 1'b0;
         st.month_alarm[RTCA_ENABLE_BIT] <= 1'b0;
         st.carry_flag       <= RTCA_CTL1_RESET[RTCA_CARRY_BIT];
         st.carry_irq_enable <= 1'b0;
         st.alarm_irq_enable <= 1'b0;
         st.alarm_match_flag <= 1'b0;
         st.periodic_flag    <= RTCA_CTL2_RESET[RTCA_PERIODIC_BIT];
         st.period_select    <= 3'b000;
         st.oscillator_run   <= RTCA_CTL2_RESET[RTCA_OSC_RUN_BIT];
         st.calendar_start   <= RTCA_CTL2_RESET[RTCA_START_BIT];
         st.sub_second_counter <= '0;
         st.prescale   <= '0;
         st.match_seen <= 1'b0;
         st.ack        <= 1'b0;
         st.rdata      <= 32'h0000_0000;
         st.irq        <= '0;
         st.min_carry  <= 1'b0;
      // manual reset: carry flag, run and start bits survive
      end else if (mrst_i) begin
         st <= next_st;
         st.carry_irq_enable <= 1'b0;
         st.alarm_irq_enable <= 1'b0;
         st.alarm_match_flag <= 1'b0;
         st.periodic_flag    <= 1'b0;
         st.period_select    <= 3'b000;
         st.ack      <= 1'b0;
         st.irq      <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign wb_rsp_o.ack = st.ack;
   assign wb_rsp_o.dat = st.rdata;
   assign irq_o        = st.irq;
   assign osc_run_o    = st.oscillator_run;
endmodule // rtca_core

// *** rtca_pkg.sv ***
// Purpose: shared constants and carriers for the calendar alarm/control block
// Assumes: 32-bit classic Wishbone, byte-wide registers in the low lane
// Notes:   offsets are byte addresses of our own register map
package rtca_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] RTCA_DATE_ALARM_OFS   = 8'h00;
   localparam logic [7:0] RTCA_MONTH_ALARM_OFS  = 8'h04;
   localparam logic [7:0] RTCA_CONTROL_ONE_OFS  = 8'h08;
   localparam logic [7:0] RTCA_CONTROL_TWO_OFS  = 8'h0C;
   localparam logic [7:0] RTCA_SECONDS_OFS      = 8'h10;
   localparam logic [7:0] RTCA_DATE_OFS         = 8'h14;
   localparam logic [7:0] RTCA_MONTH_OFS        = 8'h18;
   localparam logic [7:0] RTCA_SUBSEC_OFS       = 8'h1C;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int RTCA_ENABLE_BIT     = 7;
   localparam int RTCA_CARRY_BIT      = 7;
   localparam int RTCA_CARRY_IE_BIT   = 4;
   localparam int RTCA_ALARM_IE_BIT   = 3;
   localparam int RTCA_ALARM_BIT      = 0;
   localparam int RTCA_PERIODIC_BIT   = 7;
   localparam int RTCA_PSEL_LSB       = 4;
   localparam int RTCA_OSC_RUN_BIT    = 3;
   localparam int RTCA_ROUND_BIT      = 2;
   localparam int RTCA_DIV_RESET_BIT  = 1;
   localparam int RTCA_START_BIT      = 0;
   // ----------------------------------------------------------------
   // reset values and masks
   // ----------------------------------------------------------------
   localparam logic [7:0] RTCA_CTL1_RESET   = 8'h00;
   localparam logic [7:0] RTCA_CTL2_RESET   = 8'h09;
   localparam logic [7:0] RTCA_CTL1_RW_MASK = 8'h99;
   localparam logic [7:0] RTCA_DATE_MASK    = 8'hBF;
   localparam logic [7:0] RTCA_MONTH_MASK   = 8'h9F;
   localparam logic [7:0] RTCA_DATE_FIRST   = 8'h01;
   localparam logic [7:0] RTCA_SECOND_RND   = 8'h30;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int RTCA_CLK_HZ        = 200_000_000;
   localparam int RTCA_XTAL_HZ       = 32_768;
   localparam int RTCA_TICK_CYCLES   = RTCA_CLK_HZ / RTCA_XTAL_HZ;
   localparam int RTCA_SUBSEC_WIDTH  = 7;
   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } rtca_wb_req_s;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } rtca_wb_rsp_s;

   typedef struct packed {
      logic carry;
      logic alarm;
      logic periodic;
   } rtca_irq_s;
endpackage

// *** rtca_tick.sv ***
// Purpose: crystal-rate tick generator from the system clock
// Assumes: divider period fits 16 bits
// Notes:   stops while the oscillator is disabled
`timescale 1ns/1ps
module rtca_tick
   import rtca_pkg::*;
#(
   parameter int DIV = RTCA_TICK_CYCLES
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic run_i,
   input  wire logic clr_i,
   output logic      tick_o
);
   typedef struct packed {
      logic [15:0] cnt;
      logic        tick;
   } rtca_tick_s;
   rtca_tick_s st, next_st;

   // count system cycles into one crystal period
   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      if (clr_i || !run_i) begin
         next_st.cnt = 16'h0000;
      end else if (st.cnt == 16'(DIV - 1)) begin
         next_st.cnt = 16'h0000;
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = st.cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign tick_o = st.tick;
endmodule // rtca_tick

// *** rtca_bcd.sv ***
// Purpose: one BCD counter stage with wrap value and load
// Assumes: values stay in range by software
// Notes:   carry_o is combinational on the stage wrap
`timescale 1ns/1ps
module rtca_bcd
   import rtca_pkg::*;
#(
   parameter logic [7:0] FIRST = 8'h00,
   parameter logic [7:0] LAST  = 8'h59
) (
   input  wire logic       clk_i,
   input  wire logic       inc_i,
   input  wire logic       load_i,
   input  wire logic [7:0] load_val_i,
   output logic [7:0]      val_o,
   output logic            carry_o
);
   typedef struct packed {
      logic [7:0] val;
   } rtca_bcd_s;
   rtca_bcd_s st, next_st;

   // bcd increment with wrap to the first value
   always_comb begin
      next_st = st;
      if (load_i) begin
         next_st.val = load_val_i;
      end else if (inc_i) begin
         if (st.val == LAST) begin
            next_st.val = FIRST;
         end else if (st.val[3:0] == 4'h9) begin
            next_st.val = {st.val[7:4] + 4'h1, 4'h0};
         end else begin
            next_st.val = st.val + 8'h01;
         end
      end
   end

   // counters keep contents through every reset
   always_ff @(posedge clk_i) begin
      st <= next_st;
   end
   assign val_o   = st.val;
   assign carry_o = inc_i && (st.val == LAST);
endmodule // rtca_bcd

// *** rtca_core_sva.sv ***
// Purpose: port-level checks of the alarm/control block
// Assumes: one clock, sync active-high power-on and manual resets
// Notes:   bound to rtca_core after the module
`timescale 1ns/1ps
module rtca_core_sva
   import rtca_pkg::*;
(
   input wire logic         clk_i,
   input wire logic         rst_i,
   input wire logic         mrst_i,
   input wire rtca_wb_req_s wb_req_i,
   input wire logic         day_carry_i,
   input wire logic         other_alarm_match_i,
   input wire rtca_wb_rsp_s wb_rsp_o,
   input wire rtca_irq_s    irq_o,
   input wire logic         osc_run_o,
   input wire logic         minute_carry_o
);
   // ----------------------------------------------------------------
   // decoded accesses at the answer edge
   // ----------------------------------------------------------------
   logic wr_one;
   logic wr_two;
   logic rd_one;
   logic rd_two;
   // write or read seen while ack is high
   assign wr_one = wb_rsp_o.ack && wb_req_i.we && wb_req_i.sel[0]
                   && wb_req_i.adr == RTCA_CONTROL_ONE_OFS;
   assign wr_two = wb_rsp_o.ack && wb_req_i.we && wb_req_i.sel[0]
                   && wb_req_i.adr == RTCA_CONTROL_TWO_OFS;
   assign rd_one = wb_rsp_o.ack && !wb_req_i.we
                   && wb_req_i.adr == RTCA_CONTROL_ONE_OFS;
   assign rd_two = wb_rsp_o.ack && !wb_req_i.we
                   && wb_req_i.adr == RTCA_CONTROL_TWO_OFS;
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_answers_req: assert property (wb_req_i.cyc && wb_req_i.stb
      && !wb_rsp_o.ack |=> wb_rsp_o.ack) else $error("ack missing");
   a_ack_one_cycle: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
      else $error("ack held too long");
   a_upper_data_zero: assert property (wb_rsp_o.ack |->
      wb_rsp_o.dat[31:8] == 24'h0) else $error("upper data not zero");
   a_reserved_read_zero: assert property (rd_one |->
      wb_rsp_o.dat[6:5] == 2'b00 && wb_rsp_o.dat[2:1] == 2'b00)
      else $error("reserved control one bits set");
   a_strobes_read_zero: assert property (rd_two |->
      wb_rsp_o.dat[2:1] == 2'b00)
      else $error("round or divider reset bit reads one");
   a_osc_run_on: assert property (wr_two && wb_req_i.dat[3] |->
      ##[1:2] osc_run_o) else $error("oscillator not running");
   a_osc_run_off: assert property (wr_two && !wb_req_i.dat[3] |->
      ##[1:2] !osc_run_o) else $error("oscillator not halted");
   a_alarm_irq_mask: assert property (wr_one && !wb_req_i.dat[3] |->
      ##[1:3] !irq_o.alarm) else $error("alarm irq not masked");
   a_carry_irq_mask: assert property (wr_one && !wb_req_i.dat[4] |->
      ##[1:3] !irq_o.carry) else $error("carry irq not masked");
   a_manual_irq_off: assert property (mrst_i |->
      ##[1:3] irq_o == 3'b000) else $error("irq after manual reset");
   a_por_outputs: assert property (disable iff (1'b0) $fell(rst_i) |->
      osc_run_o && irq_o == 3'b000)
      else $error("outputs wrong after power-on reset");
endmodule // rtca_core_sva

bind rtca_core rtca_core_sva i_sva (
   .clk_i(clk_i), .rst_i(rst_i), .mrst_i(mrst_i), .wb_req_i(wb_req_i),
   .day_carry_i(day_carry_i), .other_alarm_match_i(other_alarm_match_i),
   .wb_rsp_o(wb_rsp_o), .irq_o(irq_o), .osc_run_o(osc_run_o),
   .minute_carry_o(minute_carry_o)
);

// *** rtca_core_tb.sv ***
// Purpose: self-checking bench of the alarm/control block
// Assumes: TICK_DIV shortened to 4 system cycles per crystal tick
// Notes:   classic Wishbone master driven on rising edges
`timescale 1ns/1ps
module rtca_core_tb
   import rtca_pkg::*;
;
   logic         clk_i;
   logic         rst_i;
   logic         mrst_i;
   rtca_wb_req_s req;
   rtca_wb_rsp_s rsp;
   logic         day_carry_i;
   logic         match_i;
   rtca_irq_s    irq_o;
   logic         osc_run_o;
   logic         min_o;
   logic [7:0]   q;
   int           n_mismatch;
   int           comparisons;
   // ----------------------------------------------------------------
   // device under test
   // ----------------------------------------------------------------
   rtca_core #(.TICK_DIV(4)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .mrst_i(mrst_i), .wb_req_i(req),
      .day_carry_i(day_carry_i), .other_alarm_match_i(match_i),
      .wb_rsp_o(rsp), .irq_o(irq_o), .osc_run_o(osc_run_o),
      .minute_carry_o(min_o)
   );
   // 200 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one classic cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] r);
      int n;
      n = 0;
      @(posedge clk_i);
      req <= '{1'b1, 1'b1, w, a, 4'h1, {24'h00_0000, d}};
      do begin
         @(posedge clk_i);
         n++;
      end while (rsp.ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         chk("ack timeout", 8'h01, 8'h00);
         print_verdict();
      end
      r = rsp.dat[7:0];
      req <= '0;
   endtask
   // bounded wait for an irq bit to reach a level
   task automatic wait_irq(input int b, input logic lv, input int lim);
      int n;
      n = 0;
      while (irq_o[b] !== lv && n < lim) begin
         @(posedge clk_i);
         n++;
      end
      chk("irq wait", {7'h00, lv}, {7'h00, irq_o[b]});
      if (n >= lim) print_verdict();
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      wb(0, RTCA_CONTROL_ONE_OFS, 8'h00, q); chk("ctl one", 8'h00, q);
      wb(0, RTCA_CONTROL_TWO_OFS, 8'h00, q); chk("ctl two", 8'h09, q);
      wb(0, RTCA_DATE_ALARM_OFS, 8'h00, q); chk("date en", 8'h00, q & 8'h80);
      wb(0, RTCA_MONTH_ALARM_OFS, 8'h00, q); chk("mon en", 8'h00, q & 8'h80);
      chk("osc run", 8'h01, {7'h00, osc_run_o});
      wb(0, 8'h20, 8'h00, q); chk("unmapped", 8'h00, q);
   endtask
   task automatic t_control();
      logic [7:0] s;
      wb(1, RTCA_CONTROL_ONE_OFS, 8'h7F, q);
      wb(0, RTCA_CONTROL_ONE_OFS, 8'h00, q); chk("ctl one rsv", 8'h18, q);
      wb(1, RTCA_CONTROL_TWO_OFS, 8'h0A, q);
      wb(0, RTCA_CONTROL_TWO_OFS, 8'h00, q); chk("div reset", 8'h08, q);
      for (int i = 0; i < 2; i++) begin
         s = (i == 0) ? 8'h12 : 8'h45;
         wb(1, RTCA_SECONDS_OFS, s, q);
         wb(1, RTCA_CONTROL_TWO_OFS, 8'h0C, q);
         chk("min carry", {7'h00, s >= 8'h30}, {7'h00, min_o});
         wb(0, RTCA_SECONDS_OFS, 8'h00, q); chk("rounded", 8'h00, q);
         wb(0, RTCA_CONTROL_TWO_OFS, 8'h00, q); chk("round rd", 8'h08, q);
      end
      wb(1, RTCA_CONTROL_TWO_OFS, 8'h00, q);
      repeat (3) @(posedge clk_i);
      chk("osc halt", 8'h00, {7'h00, osc_run_o});
      wb(1, RTCA_CONTROL_TWO_OFS, 8'h08, q);
   endtask
   task automatic t_alarm();
      wb(1, RTCA_DATE_OFS, 8'h05, q);
      wb(0, RTCA_DATE_OFS, 8'h00, q); chk("date cnt", 8'h05, q);
      wb(1, RTCA_MONTH_ALARM_OFS, 8'h01, q);
      wb(1, RTCA_DATE_ALARM_OFS, 8'h86, q);
      wb(1, RTCA_CONTROL_ONE_OFS, 8'h08, q);
      match_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      chk("no alarm", 8'h00, {7'h00, irq_o.alarm});
      match_i <= 1'b0;
      wb(1, RTCA_DATE_ALARM_OFS, 8'h85, q);
      wb(0, RTCA_DATE_ALARM_OFS, 8'h00, q); chk("date alm", 8'h85, q);
      match_i <= 1'b1;
      wait_irq(1, 1'b1, 20);
      wb(0, RTCA_CONTROL_ONE_OFS, 8'h00, q); chk("alarm flag", 8'h09, q);
      wb(1, RTCA_CONTROL_ONE_OFS, 8'h01, q);
      wait_irq(1, 1'b0, 5);
      wb(0, RTCA_CONTROL_ONE_OFS, 8'h00, q); chk("flag kept", 8'h01, q);
      wb(1, RTCA_CONTROL_ONE_OFS, 8'h00, q);
      wb(0, RTCA_CONTROL_ONE_OFS, 8'h00, q); chk("flag clr", 8'h00, q);
   endtask
   task automatic t_period();
      logic [7:0] v;
      for (int k = 1; k <= 2; k++) begin
         v = {1'b0, 3'(k), 4'h9};
         wb(1, RTCA_CONTROL_TWO_OFS, v, q);
         wait_irq(0, 1'b1, 1024 << (2 * (k - 1)));
         wb(0, RTCA_CONTROL_TWO_OFS, 8'h00, q); chk("per flag", v | 8'h80, q);
         wb(1, RTCA_CONTROL_TWO_OFS, v, q);
         wb(0, RTCA_CONTROL_TWO_OFS, 8'h00, q); chk("per clr", v, q);
      end
      wb(1, RTCA_CONTROL_TWO_OFS, 8'h09, q);
      repeat (1100) @(posedge clk_i);
      chk("no period", 8'h00, {7'h00, irq_o.periodic});
   endtask
   task automatic t_carry();
      int n;
      n = 0;
      wb(1, RTCA_CONTROL_ONE_OFS, 8'h10, q);
      while (irq_o.carry !== 1'b1 && n < 2200) begin
         wb(0, RTCA_SUBSEC_OFS, 8'h00, q);
         n++;
      end
      chk("carry irq", 8'h01, {7'h00, irq_o.carry});
      wb(0, RTCA_CONTROL_ONE_OFS, 8'h00, q);
      chk("carry flag", 8'h90, q);
      wb(1, RTCA_CONTROL_ONE_OFS, 8'h00, q);
      wait_irq(2, 1'b0, 5);
   endtask
   task automatic t_manual();
      wb(1, RTCA_CONTROL_ONE_OFS, 8'h18, q);
      wb(1, RTCA_CONTROL_TWO_OFS, 8'h10, q);
      @(posedge clk_i);
      mrst_i <= 1'b1;
      @(posedge clk_i);
      mrst_i <= 1'b0;
      wb(0, RTCA_CONTROL_ONE_OFS, 8'h00, q); chk("mrst one", 8'h00, q & 8'h7F);
      wb(0, RTCA_CONTROL_TWO_OFS, 8'h00, q); chk("mrst two", 8'h00, q);
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      n_mismatch = 0;
      comparisons = 0;
      rst_i = 1'b1;
      mrst_i = 1'b0;
      req = '0;
      day_carry_i = 1'b0;
      match_i = 1'b0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_control();
      t_alarm();
      t_period();
      t_carry();
      t_manual();
      print_verdict();
   end
endmodule // rtca_core_tb
